// ==== rtl/hms_pkg.sv ====
// package of register addresses, field positions and reset values for the handshake block
package hms_pkg;

	// =====================================================================
	// register addresses on the three-bit host address lines
	// =====================================================================
	localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] ADDR_HANDSHAKE_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_HANDSHAKE_STATUS = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH_STORE = 3'h7;

	// =====================================================================
	// handshake_control field positions
	// =====================================================================
	localparam int CTL_TERM_READY = 0;
	localparam int CTL_REQ_SEND = 1;
	localparam int CTL_USER_ONE = 2;
	localparam int CTL_USER_TWO = 3;
	localparam int CTL_LOOP = 4;
	localparam int CTL_WIDTH = 5;

	// =====================================================================
	// line index inside the four-line vectors, status layout
	// =====================================================================
	localparam int LINE_CLEAR_SEND = 0;
	localparam int LINE_SET_READY = 1;
	localparam int LINE_RING = 2;
	localparam int LINE_CARRIER = 3;
	localparam int STS_STATE_LSB = 4;

	// interrupt enable field: bit 3 gates the handshake interrupt
	localparam int IRQ_EN_HANDSHAKE = 3;
	localparam int IRQ_EN_WIDTH = 4;

	// =====================================================================
	// synchroniser bit positions, reset values
	// =====================================================================
	localparam int SYN_CLEAR_SEND_N = 0;
	localparam int SYN_SET_READY_N = 1;
	localparam int SYN_RING_N = 2;
	localparam int SYN_CARRIER_N = 3;
	localparam int SYN_RX = 4;
	localparam int SYN_CHIP_SELECT_ONE = 5;
	localparam int SYN_MODE_SELECT_N = 6;
	localparam int SYN_WIDTH = 7;
	localparam logic [SYN_WIDTH-1:0] SYN_RESET = 7'h7F;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [CTL_WIDTH-1:0] RST_CONTROL = 5'h00;
	localparam logic [IRQ_EN_WIDTH-1:0] RST_IRQ_EN = 4'h0;
	localparam logic [3:0] RST_LINES = 4'h0;

endpackage

// ==== rtl/hms_pin_sync.sv ====
// three-stage pin synchroniser whose output moves only once stages two and three agree
`timescale 1ns/1ps
module hms_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// asynchronous pins in, filtered level out
	input wire logic [W-1:0] pin_async,
	output logic [W-1:0] pin_level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
	} hms_sync_s;

	hms_sync_s st;
	hms_sync_s next_st;

	// stage one feeds only stage two; the filter looks at two and three
	always_comb begin
		next_st = st;
		next_st.s1 = pin_async;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s3[i];
			end
		end
	end

	// idle value at reset avoids a phantom edge on release
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= {INIT, INIT, INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign pin_level = st.level;

endmodule

// ==== rtl/hms_handshake.sv ====
// modem handshake control, status, loopback and scratch register section of a serial controller
//
// What this block does
// R1: terminal-ready control bit drives its active-low pin inverted.
// R2: request-to-send control bit one drives its active-low pin inverted.
// R3: first user output bit drives its active-low pin inverted.
// R4: second user output bit drives its active-low pin inverted.
// R5: control register bits five to seven always read zero.
// R6: loopback bit four holds the serial transmit pin at marking level one.
// R7: in loopback the receive pin is ignored, transmit shifter feeds receive shifter.
// R8: in loopback handshake inputs disconnect, controls loop inward, outputs held high.
// R9: in loopback handshake interrupts still work, sourced from control bits, still gated.
// R10: change flags set on line change (ring on on-to-off only), clear on status read unless a line changes in that cycle.
// R11: clear-to-send and set-ready change flags latch toggles since last status read.
// R12: carrier change flag at status bit three latches toggles since last read.
// R13: ring flag sets only on on-to-off transition, never on off-to-on.
// R14: any change flag set raises the handshake interrupt request, subject to enable.
// R15: clear-to-send status is inverted pin, or request-to-send bit in loopback.
// R16: set-ready status is inverted pin, or terminal-ready bit in loopback.
// R17: ring status is inverted pin, or first user output bit in loopback.
// R18: carrier status is inverted pin, or second user output bit in loopback.
// R19: scratch register at address seven stores eight bits, affects nothing else.
// R20: with mode select low, scratch bit zero reads chip-select-one pin.
// R21: handshake interrupt reaches the output only while its enable bit is one.
// R22: handshake interrupt has lowest priority; status read clears it.
// R23: status bits 0-3 change flags, bits 4-7 line states in order.
// R24: inputs sampled synchronously, compared with previous; a new change beats read clear.
`timescale 1ns/1ps
module hms_handshake (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// host register port, one access per cycle
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// handshake pins, all active low
	input wire logic clear_send_n,
	input wire logic set_ready_n,
	input wire logic ring_state_n,
	input wire logic carrier_state_n,
	output logic term_ready_n,
	output logic req_send_n,
	output logic user_output_one_n,
	output logic user_output_two_n,
	// serial pins and the shift register taps of the transmitter and receiver
	input wire logic serial_rx_pin,
	input wire logic tx_shift_out,
	output logic serial_tx_pin,
	output logic rx_shift_in,
	// mode select and chip select pins
	input wire logic output_control_mode_select_n,
	input wire logic chip_select_one,
	// interrupt: higher-priority sources pending, requests out
	input wire logic higher_irq_pending,
	output logic handshake_irq,
	output logic handshake_irq_selected
);

	typedef struct packed {
		logic [hms_pkg::CTL_WIDTH-1:0] ctl;
		logic [7:0] scratch;
		logic [hms_pkg::IRQ_EN_WIDTH-1:0] irq_en;
		logic [3:0] prev;
		logic [3:0] delta;
		logic [7:0] rdata;
		logic term_ready_n;
		logic req_send_n;
		logic user_one_n;
		logic user_two_n;
		logic tx_pin;
		logic rx_in;
		logic irq;
		logic irq_sel;
	} hms_state_s;

	hms_state_s st;
	hms_state_s next_st;
	logic [hms_pkg::SYN_WIDTH-1:0] pins;
	logic [3:0] lines_now;
	logic loop_on;

	// =====================================================================
	// pin synchronisation
	// =====================================================================
	hms_pin_sync #(
		.W(hms_pkg::SYN_WIDTH),
		.INIT(hms_pkg::SYN_RESET)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.pin_async({output_control_mode_select_n, chip_select_one, serial_rx_pin,
			carrier_state_n, ring_state_n, set_ready_n, clear_send_n}),
		.pin_level(pins)
	);

	// returns a control byte with the unused upper bits forced to zero
	function automatic logic [7:0] ctl_byte(input logic [hms_pkg::CTL_WIDTH-1:0] c);
		ctl_byte = {3'h0, c};
	endfunction

	// =====================================================================
	// current line states: pins inverted, or control bits looped inward
	// =====================================================================
	assign loop_on = st.ctl[hms_pkg::CTL_LOOP];
	always_comb begin
		if (loop_on) begin
			lines_now[hms_pkg::LINE_CLEAR_SEND] = st.ctl[hms_pkg::CTL_REQ_SEND]; // R15 R8
			lines_now[hms_pkg::LINE_SET_READY] = st.ctl[hms_pkg::CTL_TERM_READY]; // R16
			lines_now[hms_pkg::LINE_RING] = st.ctl[hms_pkg::CTL_USER_ONE]; // R17
			lines_now[hms_pkg::LINE_CARRIER] = st.ctl[hms_pkg::CTL_USER_TWO]; // R18
		end else begin
			lines_now[hms_pkg::LINE_CLEAR_SEND] = ~pins[hms_pkg::SYN_CLEAR_SEND_N]; // R15
			lines_now[hms_pkg::LINE_SET_READY] = ~pins[hms_pkg::SYN_SET_READY_N]; // R16
			lines_now[hms_pkg::LINE_RING] = ~pins[hms_pkg::SYN_RING_N]; // R17
			lines_now[hms_pkg::LINE_CARRIER] = ~pins[hms_pkg::SYN_CARRIER_N]; // R18
		end
	end

	// =====================================================================
	// next-state logic
	// =====================================================================
	always_comb begin
		logic rd_status;
		logic [3:0] set_now;
		rd_status = 1'b0;
		set_now = 4'h0;
		next_st = st;

		// register writes; status is read-only
		if (reg_wr) begin
			case (reg_addr)
				hms_pkg::ADDR_HANDSHAKE_CONTROL: begin
					next_st.ctl = reg_wdata[hms_pkg::CTL_WIDTH-1:0]; // R5
				end
				hms_pkg::ADDR_SCRATCH_STORE: begin
					next_st.scratch = reg_wdata; // R19
				end
				hms_pkg::ADDR_IRQ_ENABLE: begin
					next_st.irq_en = reg_wdata[hms_pkg::IRQ_EN_WIDTH-1:0];
				end
				default: begin
					next_st.ctl = st.ctl;
				end
			endcase
		end

		// read data is captured so it stands until the next read
		if (reg_rd) begin
			case (reg_addr)
				hms_pkg::ADDR_HANDSHAKE_CONTROL: begin
					next_st.rdata = ctl_byte(st.ctl); // R5
				end
				hms_pkg::ADDR_HANDSHAKE_STATUS: begin
					next_st.rdata = {lines_now, st.delta}; // R23
					rd_status = 1'b1;
				end
				hms_pkg::ADDR_SCRATCH_STORE: begin
					next_st.rdata = st.scratch;
					if (!pins[hms_pkg::SYN_MODE_SELECT_N]) begin
						next_st.rdata[0] = pins[hms_pkg::SYN_CHIP_SELECT_ONE]; // R20
					end
				end
				hms_pkg::ADDR_IRQ_ENABLE: begin
					next_st.rdata = {4'h0, st.irq_en};
				end
				default: begin
					next_st.rdata = hms_pkg::RST_BYTE;
				end
			endcase
		end

		// change detection against the previous sample
		set_now[hms_pkg::LINE_CLEAR_SEND] = lines_now[0] ^ st.prev[0]; // R11 R24
		set_now[hms_pkg::LINE_SET_READY] = lines_now[1] ^ st.prev[1]; // R11
		set_now[hms_pkg::LINE_RING] = st.prev[2] & ~lines_now[2]; // R13
		set_now[hms_pkg::LINE_CARRIER] = lines_now[3] ^ st.prev[3]; // R12
		next_st.prev = lines_now;

		// a change in the reading cycle survives the clear
		next_st.delta = (rd_status ? 4'h0 : st.delta) | set_now; // R10 R24 R22

		// pins follow the next control value, forced inactive in loopback
		next_st.term_ready_n = ~(next_st.ctl[hms_pkg::CTL_TERM_READY] &
			~next_st.ctl[hms_pkg::CTL_LOOP]); // R1 R8
		next_st.req_send_n = ~(next_st.ctl[hms_pkg::CTL_REQ_SEND] &
			~next_st.ctl[hms_pkg::CTL_LOOP]); // R2 R8
		next_st.user_one_n = ~(next_st.ctl[hms_pkg::CTL_USER_ONE] &
			~next_st.ctl[hms_pkg::CTL_LOOP]); // R3 R8
		next_st.user_two_n = ~(next_st.ctl[hms_pkg::CTL_USER_TWO] &
			~next_st.ctl[hms_pkg::CTL_LOOP]); // R4 R8

		// serial path: marking level out and internal loop in diagnostics
		next_st.tx_pin = next_st.ctl[hms_pkg::CTL_LOOP] ? 1'b1 : tx_shift_out; // R6
		next_st.rx_in = next_st.ctl[hms_pkg::CTL_LOOP] ? tx_shift_out :
			pins[hms_pkg::SYN_RX]; // R7

		// interrupt works the same in loopback, sources are just the looped lines
		next_st.irq = (|next_st.delta) & next_st.irq_en[hms_pkg::IRQ_EN_HANDSHAKE]; // R14 R21 R9
		next_st.irq_sel = next_st.irq & ~higher_irq_pending; // R22
	end

	// =====================================================================
	// state register
	// =====================================================================
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.ctl <= hms_pkg::RST_CONTROL;
			st.scratch <= hms_pkg::RST_BYTE;
			st.irq_en <= hms_pkg::RST_IRQ_EN;
			st.prev <= hms_pkg::RST_LINES;
			st.delta <= hms_pkg::RST_LINES;
			st.rdata <= hms_pkg::RST_BYTE;
			st.term_ready_n <= 1'b1;
			st.req_send_n <= 1'b1;
			st.user_one_n <= 1'b1;
			st.user_two_n <= 1'b1;
			st.tx_pin <= 1'b1;
			st.rx_in <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from the state register
	assign reg_rdata = st.rdata;
	assign term_ready_n = st.term_ready_n;
	assign req_send_n = st.req_send_n;
	assign user_output_one_n = st.user_one_n;
	assign user_output_two_n = st.user_two_n;
	assign serial_tx_pin = st.tx_pin;
	assign rx_shift_in = st.rx_in;
	assign handshake_irq = st.irq;
	assign handshake_irq_selected = st.irq_sel;

	// =====================================================================
	// assertions
	// =====================================================================
	term_ready_pin_a: assert property (@(posedge mclk) disable iff (rst) // R1
		(reg_wr && reg_addr == hms_pkg::ADDR_HANDSHAKE_CONTROL && reg_wdata[0] && !reg_wdata[4])
		|=> !term_ready_n)
		else $error("terminal ready pin not driven low");

	req_send_pin_a: assert property (@(posedge mclk) disable iff (rst) // R2
		(reg_wr && reg_addr == hms_pkg::ADDR_HANDSHAKE_CONTROL && !reg_wdata[1])
		|=> req_send_n)
		else $error("request to send pin not high");

	user_pins_a: assert property (@(posedge mclk) disable iff (rst) // R3
		(reg_wr && reg_addr == hms_pkg::ADDR_HANDSHAKE_CONTROL && reg_wdata[3:2] == 2'h3 &&
		!reg_wdata[4]) |=> (!user_output_one_n && !user_output_two_n))
		else $error("user output pins not low");

	ctl_upper_zero_a: assert property (@(posedge mclk) disable iff (rst) // R5
		(reg_rd && reg_addr == hms_pkg::ADDR_HANDSHAKE_CONTROL) |=> reg_rdata[7:5] == 3'h0)
		else $error("control upper bits read nonzero");

	loop_marking_a: assert property (@(posedge mclk) disable iff (rst) // R6
		st.ctl[hms_pkg::CTL_LOOP] |-> (serial_tx_pin && term_ready_n && req_send_n &&
		user_output_one_n && user_output_two_n))
		else $error("loopback outputs not inactive");

	loop_rx_path_a: assert property (@(posedge mclk) disable iff (rst) // R7
		(st.ctl[hms_pkg::CTL_LOOP] && next_st.ctl[hms_pkg::CTL_LOOP]) |=>
		rx_shift_in == $past(tx_shift_out))
		else $error("loopback receive path broken");

	loop_cts_a: assert property (@(posedge mclk) disable iff (rst) // R15
		loop_on |-> lines_now[hms_pkg::LINE_CLEAR_SEND] == st.ctl[hms_pkg::CTL_REQ_SEND])
		else $error("looped clear to send wrong");

	change_sets_a: assert property (@(posedge mclk) disable iff (rst) // R10
		(lines_now[hms_pkg::LINE_CARRIER] != st.prev[hms_pkg::LINE_CARRIER])
		|=> st.delta[hms_pkg::LINE_CARRIER])
		else $error("carrier change not latched");

	ring_edge_a: assert property (@(posedge mclk) disable iff (rst) // R13
		($fell(lines_now[hms_pkg::LINE_RING]) ##0 !st.delta[hms_pkg::LINE_RING])
		|=> st.delta[hms_pkg::LINE_RING])
		else $error("ring trailing edge missed");

	status_clear_a: assert property (@(posedge mclk) disable iff (rst) // R10
		(reg_rd && reg_addr == hms_pkg::ADDR_HANDSHAKE_STATUS && lines_now == st.prev)
		|=> st.delta == 4'h0)
		else $error("status read did not clear flags");

	irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // R21
		handshake_irq |-> (st.irq_en[hms_pkg::IRQ_EN_HANDSHAKE] && st.delta != 4'h0))
		else $error("interrupt without enable or flag");

	irq_raise_a: assert property (@(posedge mclk) disable iff (rst) // R14
		(st.delta != 4'h0 && st.irq_en[hms_pkg::IRQ_EN_HANDSHAKE] && !reg_wr &&
		!(reg_rd && reg_addr == hms_pkg::ADDR_HANDSHAKE_STATUS)) |=> handshake_irq)
		else $error("interrupt not raised");

	scratch_store_a: assert property (@(posedge mclk) disable iff (rst) // R19
		(reg_wr && reg_addr == hms_pkg::ADDR_SCRATCH_STORE) ##1 !reg_wr ##1
		(reg_rd && !reg_wr && reg_addr == hms_pkg::ADDR_SCRATCH_STORE &&
		pins[hms_pkg::SYN_MODE_SELECT_N]) |=> reg_rdata == $past(reg_wdata, 3))
		else $error("scratch readback mismatch");

	scratch_cs_a: assert property (@(posedge mclk) disable iff (rst) // R20
		(reg_rd && reg_addr == hms_pkg::ADDR_SCRATCH_STORE && !pins[hms_pkg::SYN_MODE_SELECT_N])
		|=> reg_rdata[0] == $past(pins[hms_pkg::SYN_CHIP_SELECT_ONE]))
		else $error("chip select bit not reflected");

	irq_priority_a: assert property (@(posedge mclk) disable iff (rst) // R22
		handshake_irq_selected |-> (handshake_irq && !$past(higher_irq_pending)))
		else $error("handshake interrupt beat higher priority");

	user_two_pin_a: assert property (@(posedge mclk) disable iff (rst) // R4
		(reg_wr && reg_addr == hms_pkg::ADDR_HANDSHAKE_CONTROL && !reg_wdata[3])
		|=> user_output_two_n)
		else $error("second user output pin not high");

	clear_send_change_a: assert property (@(posedge mclk) disable iff (rst) // R11
		(lines_now[hms_pkg::LINE_CLEAR_SEND] != st.prev[hms_pkg::LINE_CLEAR_SEND])
		|=> st.delta[hms_pkg::LINE_CLEAR_SEND])
		else $error("clear to send change not latched");

	set_ready_change_a: assert property (@(posedge mclk) disable iff (rst) // R11
		(lines_now[hms_pkg::LINE_SET_READY] != st.prev[hms_pkg::LINE_SET_READY])
		|=> st.delta[hms_pkg::LINE_SET_READY])
		else $error("set ready change not latched");

	// a ring turning on must leave a clear trailing-edge flag clear
	ring_rise_quiet_a: assert property (@(posedge mclk) disable iff (rst) // R13
		($rose(lines_now[hms_pkg::LINE_RING]) && !st.delta[hms_pkg::LINE_RING])
		|=> !st.delta[hms_pkg::LINE_RING])
		else $error("ring flag set on leading edge");

	loop_set_ready_a: assert property (@(posedge mclk) disable iff (rst) // R16
		loop_on |-> lines_now[hms_pkg::LINE_SET_READY] == st.ctl[hms_pkg::CTL_TERM_READY])
		else $error("looped set ready wrong");

	loop_ring_a: assert property (@(posedge mclk) disable iff (rst) // R17
		loop_on |-> lines_now[hms_pkg::LINE_RING] == st.ctl[hms_pkg::CTL_USER_ONE])
		else $error("looped ring state wrong");

	loop_carrier_a: assert property (@(posedge mclk) disable iff (rst) // R18
		loop_on |-> lines_now[hms_pkg::LINE_CARRIER] == st.ctl[hms_pkg::CTL_USER_TWO])
		else $error("looped carrier state wrong");

	status_lines_a: assert property (@(posedge mclk) disable iff (rst) // R23
		(reg_rd && reg_addr == hms_pkg::ADDR_HANDSHAKE_STATUS)
		|=> reg_rdata[7:4] == $past(lines_now))
		else $error("status line states wrong");

endmodule

// ==== bench/hms_modem_model.sv ====
// modem-side model that drives the four active-low handshake inputs of the block
`timescale 1ns/1ps
module hms_modem_model (
	// clock
	input wire logic mclk,
	// handshake lines towards the block, active low
	output logic clear_send_n,
	output logic set_ready_n,
	output logic ring_state_n,
	output logic carrier_state_n,
	// handshake line from the block, active low
	input wire logic req_send_n
);
	// =====================================================================
	// line state: bit order clear-send, set-ready, ring, carrier; idle is all off
	// =====================================================================
	logic [3:0] active = 4'h0;
	logic answer_rts = 1'b0;
	int lag = 0;
	int wait_count = 0;

	// pins are the inverse of the active levels
	assign clear_send_n = ~active[0];
	assign set_ready_n = ~active[1];
	assign ring_state_n = ~active[2];
	assign carrier_state_n = ~active[3];

	// lines change only just after a falling edge, like the rest of the bench
	task automatic set_lines(input logic [3:0] lines);
		@(negedge mclk);
		active = lines;
	endtask

	// slow answer: clear-to-send follows request-to-send after lag cycles
	always @(negedge mclk) begin
		if (!answer_rts || (active[0] == ~req_send_n)) begin
			wait_count = 0;
		end else if (wait_count >= lag) begin
			active[0] = ~req_send_n;
		end else begin
			wait_count++;
		end
	end
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the handshake control, status, loopback and scratch block
`timescale 1ns/1ps
module tb_top;
	// =====================================================================
	// stimulus and observed signals
	// =====================================================================
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic clear_send_n, set_ready_n, ring_state_n, carrier_state_n;
	logic term_ready_n, req_send_n, user_output_one_n, user_output_two_n;
	logic serial_rx_pin = 1'b1;
	logic tx_shift_out = 1'b1;
	logic serial_tx_pin, rx_shift_in;
	logic output_control_mode_select_n = 1'b1;
	logic chip_select_one = 1'b0;
	logic higher_irq_pending = 1'b0;
	logic handshake_irq, handshake_irq_selected;
	int bad_count = 0;
	int checks_done = 0;
	logic [3:0] lines;
	logic [7:0] scratch_byte;
	logic [7:0] expect_byte;

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	hms_handshake dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.clear_send_n(clear_send_n), .set_ready_n(set_ready_n), .ring_state_n(ring_state_n),
		.carrier_state_n(carrier_state_n), .term_ready_n(term_ready_n), .req_send_n(req_send_n),
		.user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
		.serial_rx_pin(serial_rx_pin), .tx_shift_out(tx_shift_out),
		.serial_tx_pin(serial_tx_pin), .rx_shift_in(rx_shift_in),
		.output_control_mode_select_n(output_control_mode_select_n),
		.chip_select_one(chip_select_one), .higher_irq_pending(higher_irq_pending),
		.handshake_irq(handshake_irq), .handshake_irq_selected(handshake_irq_selected));

	hms_modem_model modem (.mclk(mclk), .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
		.ring_state_n(ring_state_n), .carrier_state_n(carrier_state_n), .req_send_n(req_send_n));

	// =====================================================================
	// comparison, register access and closing tasks
	// =====================================================================
	task automatic check(input logic [7:0] seen, input logic [7:0] expected);
		checks_done++;
		if (seen !== expected) begin
			bad_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, expected);
		end
	endtask

	// one-cycle write strobe, launched and dropped at falling edges
	task automatic reg_write(input logic [2:0] addr, input logic [7:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	// read data is registered at the strobe edge and holds, so take it one falling edge after the strobe drops
	task automatic reg_read_check(input logic [2:0] addr, input logic [7:0] expected);
		@(negedge mclk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		check(reg_rdata, expected);
	endtask

	// pins cross a synchroniser: leave ample edges before looking at the result
	task automatic settle();
		repeat (8) @(negedge mclk);
	endtask

	function automatic logic [7:0] pin_outs();
		return {4'h0, user_output_two_n, user_output_one_n, req_send_n, term_ready_n};
	endfunction

	task automatic wrap_up();
		$display("checks made %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#50000;
		bad_count++;
		wrap_up();
	end

	// =====================================================================
	// test sequence
	// =====================================================================
	initial begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		check(pin_outs(), 8'h0F);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h00);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h00);
		reg_read_check(3'h0, 8'h00);
		// each control bit alone drives only its own pin low
		for (int i = 0; i < 4; i++) begin
			reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h01 << i);
			@(negedge mclk);
			check(pin_outs(), 8'h0F & ~(8'h01 << i));
		end
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'hEF);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h0F);
		check(pin_outs(), 8'h00);
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h00);
		settle();
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h00);
		// scratch store and the chip-select input port on bit zero
		scratch_byte = 8'hA5;
		reg_write(hms_pkg::ADDR_SCRATCH_STORE, scratch_byte);
		reg_read_check(hms_pkg::ADDR_SCRATCH_STORE, scratch_byte);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h00);
		output_control_mode_select_n = 1'b0;
		settle();
		reg_read_check(hms_pkg::ADDR_SCRATCH_STORE, 8'hA4);
		chip_select_one = 1'b1;
		settle();
		reg_read_check(hms_pkg::ADDR_SCRATCH_STORE, 8'hA5);
		output_control_mode_select_n = 1'b1;
		// lines turn on one at a time; ring turning on sets no flag
		reg_write(hms_pkg::ADDR_IRQ_ENABLE, 8'h08);
		lines = 4'h0;
		for (int i = 0; i < 4; i++) begin
			lines[i] = 1'b1;
			modem.set_lines(lines);
			settle();
			check({7'h0, handshake_irq}, (i == 2) ? 8'h00 : 8'h01);
			expect_byte = {lines, (i == 2) ? 4'h0 : 4'h1 << i};
			reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, expect_byte);
			check({7'h0, handshake_irq}, 8'h00);
		end
		modem.set_lines(4'h0);
		settle();
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h0F);
		// enable gating and priority against higher sources
		reg_write(hms_pkg::ADDR_IRQ_ENABLE, 8'h00);
		modem.set_lines(4'h8);
		settle();
		check({7'h0, handshake_irq}, 8'h00);
		reg_write(hms_pkg::ADDR_IRQ_ENABLE, 8'h08);
		repeat (2) @(negedge mclk);
		check({7'h0, handshake_irq}, 8'h01);
		higher_irq_pending = 1'b1;
		repeat (2) @(negedge mclk);
		check({7'h0, handshake_irq_selected}, 8'h00);
		higher_irq_pending = 1'b0;
		repeat (2) @(negedge mclk);
		check({7'h0, handshake_irq_selected}, 8'h01);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h88);
		// slow modem answers request-to-send with clear-to-send
		modem.set_lines(4'h0);
		modem.lag = 6;
		modem.answer_rts = 1'b1;
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h02);
		repeat (20) @(negedge mclk);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h19);
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h00);
		repeat (20) @(negedge mclk);
		modem.answer_rts = 1'b0;
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h01);
		// normal mode: receive shifter follows the receive pin
		serial_rx_pin = 1'b0;
		settle();
		check({7'h0, rx_shift_in}, 8'h00);
		// loopback: pins ignored, outputs idle, lines from the control bits
		modem.set_lines(4'hF);
		tx_shift_out = 1'b0;
		serial_rx_pin = 1'b1;
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h15);
		settle();
		check(pin_outs(), 8'h0F);
		check({7'h0, serial_tx_pin}, 8'h01);
		check({7'h0, rx_shift_in}, 8'h00);
		tx_shift_out = 1'b1;
		serial_rx_pin = 1'b0;
		settle();
		check({7'h0, rx_shift_in}, 8'h01);
		check({7'h0, serial_tx_pin}, 8'h01);
		// loop entry moves set-ready from off to on: only its change flag is set
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h62);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h60);
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h1A);
		settle();
		check({7'h0, handshake_irq}, 8'h01);
		reg_read_check(hms_pkg::ADDR_HANDSHAKE_STATUS, 8'h9F);
		reg_write(hms_pkg::ADDR_HANDSHAKE_CONTROL, 8'h00);
		wrap_up();
	end
endmodule
